// [hw/ocpt_top.sv]
/*
  Oscillator mode, multiplier and internal RC control with trim, behind
  an AHB-Lite slave. Assumes a single AHB master and a synchronous clock
  input pin; analog sources are steered by the level outputs.
*/
// Local design decisions: the address map and register access over AHB-Lite.
// How it works
// - No start-up delay in external clock modes
// - Plain external mode drives input divided by four
// - Crystal mode with external clock: no output
// - Enabled multiplier gives four times input, 40 MHz
// - Multiplier only in times4 configs with bit set
// - Clearing multiplier bit always stops the multiplier
// - Fast RC 8 MHz, postscaled 31 kHz to 4 MHz
// - Fast RC on for 125 kHz to 8 MHz
// - At 31 kHz, source bit picks fast RC
// - Slow RC on when selected or aux features on
// - Frequency choice direct, postscaled or slow; reset 1 MHz
// - Internal default turns both pins into port pins
// - Six-bit trim adjusts the fast RC frequency
// - New trim settles within 1 ms, no indication
// - Slow RC ignores trim entirely
// - Frequency choice resets to code 100
// - Multiplier bit reads zero outside times4 configs
`timescale 1ns/100ps
`default_nettype none
`include "ocpt_consts.svh"

module ocpt_top import ocpt_pkg::*; #(
  parameter int SETTLE_CYC = `OCPT_SETTLE_CYC
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CLOCK_IN_PIN_I,
  output logic CLOCK_IN_PIN_O,
  output logic CLOCK_IN_PIN_OE,
  input wire logic CLOCK_OUT_PIN_I,
  output logic CLOCK_OUT_PIN_O,
  output logic CLOCK_OUT_PIN_OE,
  output logic PLL_ON,
  output logic [2:0] PLL_MULT,
  output logic START_DELAY_EN,
  output logic FAST_RC_ON,
  output logic FAST_RC_DIRECT,
  output logic [2:0] POSTSCALE_SEL,
  output logic [5:0] FAST_RC_TRIM,
  output logic SLOW_RC_ON,
  output logic PINS_AS_PORT
);

  // Longest settle time rounds down; 63 steps then fit in it
  localparam int STEP_CYC = SETTLE_CYC / 64;

  // Software state
  ocpt_rcf_t rc_freq_choose_bits;
  logic [5:0] trim_field;
  logic multiplier_on_bit;
  logic low_freq_source_bit;
  logic [2:0] osc_config_field;
  logic [3:0] aux_enable;
  logic [3:0] port_ctrl;

  // Bus state
  logic wr_pend;
  logic [`OCPT_A_W-1:0] wr_addr;
  logic [31:0] rd_val;

  // Mode decode
  wire default_source_bit = osc_config_field[2];
  wire ext_mode = osc_config_field == CFG_EXT_CLK_INPUT_MODE;
  wire ext_pll_mode = osc_config_field == CFG_EXT_CLK_TIMES4_MODE;
  wire xtal_mode = osc_config_field == CFG_CRYSTAL_DRIVE_MODE;
  wire xtal_pll_mode = osc_config_field == CFG_CRYSTAL_TIMES4_MODE;
  wire pll_cfg = ext_pll_mode || xtal_pll_mode;
  wire int_default = !default_source_bit;
  wire mult_read = multiplier_on_bit && pll_cfg;
  wire div_q;

  // Bus decode
  wire acc = HSEL && HTRANS[1] && HREADY;
  wire in_range = HADDR[31:`OCPT_A_W] == '0;
  wire [`OCPT_A_W-1:0] a = HADDR[`OCPT_A_W-1:0];
  wire we_ctrl = wr_pend && wr_addr == `OCPT_A_CTRL;
  wire we_trim = wr_pend && wr_addr == `OCPT_A_TRIM;
  wire we_cfg = wr_pend && wr_addr == `OCPT_A_CFG;
  wire we_aux = wr_pend && wr_addr == `OCPT_A_AUX;
  wire we_port = wr_pend && wr_addr == `OCPT_A_PORT;

  // Single-cycle slave: no wait states, never an error
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always_comb begin
    rd_val = '0;
    if (!in_range) begin
      rd_val = '0;
    end else if (a == `OCPT_A_CTRL) begin
      rd_val[`OCPT_RCF_LSB +: 3] = rc_freq_choose_bits;
    end else if (a == `OCPT_A_TRIM) begin
      rd_val[7:0] = {low_freq_source_bit, mult_read, trim_field};
    end else if (a == `OCPT_A_CFG) begin
      rd_val[2:0] = osc_config_field;
    end else if (a == `OCPT_A_AUX) begin
      rd_val[3:0] = aux_enable;
    end else if (a == `OCPT_A_PORT) begin
      rd_val[5:0] = {CLOCK_OUT_PIN_I, CLOCK_IN_PIN_I, port_ctrl};
    end else if (a == `OCPT_A_STAT) begin
      rd_val[5:0] = {FAST_RC_DIRECT, START_DELAY_EN, PINS_AS_PORT, SLOW_RC_ON, FAST_RC_ON, PLL_ON};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      HRDATA <= '0;
    end else begin
      wr_pend <= acc && HWRITE && in_range;
      if (acc) begin
        wr_addr <= a;
      end
      if (acc && !HWRITE) begin
        HRDATA <= rd_val;
      end
    end
  end

  // Writes land in the data phase, when HWDATA stands
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rc_freq_choose_bits <= `OCPT_RCF_RST;
      trim_field <= `OCPT_TRIM_RST;
      multiplier_on_bit <= 1'b0;
      low_freq_source_bit <= 1'b0;
      osc_config_field <= `OCPT_CFG_RST;
      aux_enable <= '0;
      port_ctrl <= '0;
    end else begin
      if (we_ctrl) begin
        rc_freq_choose_bits <= HWDATA[`OCPT_RCF_LSB +: 3];
      end
      if (we_trim) begin
        trim_field <= HWDATA[`OCPT_TRIM_W-1:0];
        multiplier_on_bit <= HWDATA[`OCPT_MULT_BIT] && pll_cfg;
        low_freq_source_bit <= HWDATA[`OCPT_LFS_BIT];
      end
      if (we_cfg) begin
        osc_config_field <= HWDATA[2:0];
      end
      if (we_aux) begin
        aux_enable <= HWDATA[3:0];
      end
      if (we_port) begin
        port_ctrl <= HWDATA[3:0];
      end
    end
  end

  // Source enables follow the registers directly
  assign PLL_ON = mult_read;
  assign PLL_MULT = PLL_ON ? `OCPT_PLL_MULT : `OCPT_NO_MULT;
  assign START_DELAY_EN = xtal_mode || xtal_pll_mode;
  assign FAST_RC_ON = rc_freq_choose_bits != `OCPT_RCF_SLOW || low_freq_source_bit;
  assign FAST_RC_DIRECT = rc_freq_choose_bits == `OCPT_RCF_FULL;
  assign POSTSCALE_SEL = rc_freq_choose_bits;
  assign SLOW_RC_ON = (rc_freq_choose_bits == `OCPT_RCF_SLOW && !low_freq_source_bit) || |aux_enable;
  assign PINS_AS_PORT = int_default;

  // Pins: port function wins whenever the internal block is default
  assign CLOCK_IN_PIN_O = int_default && port_ctrl[0];
  assign CLOCK_IN_PIN_OE = int_default && port_ctrl[2];
  assign CLOCK_OUT_PIN_O = int_default ? port_ctrl[1] : div_q;
  assign CLOCK_OUT_PIN_OE = int_default ? port_ctrl[3] : ext_mode;

  ocpt_div4 #(
    .DIV_LOG2(2)
  ) u_div (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .en(ext_mode),
    .src(CLOCK_IN_PIN_I),
    .q(div_q)
  );

  // Trim reaches only the fast RC; the slow RC has no trim input
  ocpt_trim_slew #(
    .W(`OCPT_TRIM_W),
    .STEP_CYC(STEP_CYC)
  ) u_slew (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .target(trim_field),
    .applied(FAST_RC_TRIM)
  );

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  logic [31:0] settle_cnt;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || FAST_RC_TRIM == trim_field) begin
      settle_cnt <= '0;
    end else if (we_trim) begin
      settle_cnt <= 32'h1;
    end else begin
      settle_cnt <= settle_cnt + 32'h1;
    end
  end

  sequence s_trim_write;
    we_trim && (HWDATA[`OCPT_TRIM_W-1:0] != trim_field);
  endsequence

  sequence s_trim_hold;
    trim_field == $past(HWDATA[`OCPT_TRIM_W-1:0]);
  endsequence

  property p_trim_write;
    s_trim_write |=> s_trim_hold;
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("Trim write not stored");

  property p_settle;
    settle_cnt <= 32'(SETTLE_CYC);
  endproperty
  a_settle: assert property (p_settle) else $error("Trim did not settle in time");

  property p_pll;
    PLL_ON |-> pll_cfg && multiplier_on_bit && PLL_MULT == `OCPT_PLL_MULT;
  endproperty
  a_pll: assert property (p_pll) else $error("Multiplier on outside its configs");

  property p_pll_off;
    we_trim && !HWDATA[`OCPT_MULT_BIT] |=> !PLL_ON;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("Multiplier still on after clear");

  property p_mult_read;
    acc && !HWRITE && in_range && a == `OCPT_A_TRIM && !pll_cfg |=> !HRDATA[`OCPT_MULT_BIT];
  endproperty
  a_mult_read: assert property (p_mult_read) else $error("Multiplier bit read nonzero");

  property p_rcf_reset;
    $past(SYS_RST) |-> rc_freq_choose_bits == `OCPT_RCF_RST;
  endproperty
  a_rcf_reset: assert property (p_rcf_reset) else $error("Frequency choice not 1 MHz after reset");

  property p_fast;
    rc_freq_choose_bits != `OCPT_RCF_SLOW |-> FAST_RC_ON && SLOW_RC_ON == (|aux_enable);
  endproperty
  a_fast: assert property (p_fast) else $error("Fast RC off at a fast setting");

  property p_slow;
    rc_freq_choose_bits == `OCPT_RCF_SLOW |-> FAST_RC_ON == low_freq_source_bit && SLOW_RC_ON != (FAST_RC_ON && aux_enable == 4'h0);
  endproperty
  a_slow: assert property (p_slow) else $error("Low-frequency source choice wrong");

  property p_clkout;
    !ext_mode && !int_default |-> !CLOCK_OUT_PIN_OE;
  endproperty
  a_clkout: assert property (p_clkout) else $error("Clock output driven in crystal modes");

  property p_port;
    int_default |-> CLOCK_OUT_PIN_OE == port_ctrl[3] && CLOCK_IN_PIN_OE == port_ctrl[2] && !START_DELAY_EN;
  endproperty
  a_port: assert property (p_port) else $error("Pins not port pins with internal default");

  property p_nodelay;
    ext_mode || ext_pll_mode |-> !START_DELAY_EN;
  endproperty
  a_nodelay: assert property (p_nodelay) else $error("Start-up delay in external clock mode");

endmodule // ocpt_top

`default_nettype wire

// [hw/ocpt_consts.svh]
/*
  Register offsets, field positions, reset values and timing counts
  of the oscillator control block. Assumes nothing beyond inclusion.
*/
`ifndef OCPT_CONSTS_SVH
`define OCPT_CONSTS_SVH

// Byte offsets on the register bus
`define OCPT_A_CTRL 8'h00
`define OCPT_A_TRIM 8'h04
`define OCPT_A_CFG 8'h08
`define OCPT_A_AUX 8'h0C
`define OCPT_A_PORT 8'h10
`define OCPT_A_STAT 8'h14
`define OCPT_A_W 8

// osc_control_register fields
`define OCPT_RCF_LSB 4
`define OCPT_RCF_RST 3'h4
`define OCPT_RCF_SLOW 3'h0
`define OCPT_RCF_FULL 3'h7

// osc_trim_register fields
`define OCPT_TRIM_W 6
`define OCPT_TRIM_RST 6'h00
`define OCPT_MULT_BIT 6
`define OCPT_LFS_BIT 7

// config_word_low reset value
`define OCPT_CFG_RST 3'h7

// Multiplier factors
`define OCPT_PLL_MULT 3'h4
`define OCPT_NO_MULT 3'h1

// Trim settle time and clock rate
`define OCPT_SETTLE_NS 1000000
`define OCPT_CLK_MHZ 250
`define OCPT_SETTLE_CYC (`OCPT_SETTLE_NS * `OCPT_CLK_MHZ / 1000)

`endif

// [hw/ocpt_pkg.sv]
/*
  Types of the oscillator control block.
  Assumes the constants header is compiled alongside.
*/
package ocpt_pkg;

  // osc_config_field encodings; default_source_bit is bit 2
  typedef enum logic [2:0] {
    CFG_EXT_CLK_INPUT_MODE = 3'b111,
    CFG_EXT_CLK_TIMES4_MODE = 3'b110,
    CFG_CRYSTAL_DRIVE_MODE = 3'b101,
    CFG_CRYSTAL_TIMES4_MODE = 3'b100
  } ocpt_cfg_e;

  typedef logic [2:0] ocpt_rcf_t;

endpackage

// [hw/ocpt_div4.sv]
/*
  Divides an input clock, sampled on the system clock, by 2**DIV_LOG2.
  Assumes the input runs below half the system clock rate.
*/
`timescale 1ns/100ps
`default_nettype none

module ocpt_div4 #(
  parameter int DIV_LOG2 = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic src,
  output logic q
);

  logic src_d;
  logic [DIV_LOG2-1:0] cnt;
  wire rise = src & ~src_d;
  wire [DIV_LOG2-1:0] next_cnt = cnt + {{(DIV_LOG2-1){1'b0}}, rise};

  // Held low while off so the pin never idles mid-period
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      src_d <= 1'b0;
      cnt <= '0;
      q <= 1'b0;
    end else begin
      src_d <= src;
      cnt <= next_cnt;
      q <= next_cnt[DIV_LOG2-1];
    end
  end

  property p_div_edge;
    @(posedge clk) disable iff (rst)
    en && $past(en) && $changed(q) |-> $past(rise) && $past(cnt[0]);
  endproperty
  a_div_edge: assert property (p_div_edge) else $error("Divided clock moved off an input edge");

endmodule // ocpt_div4

`default_nettype wire

// [hw/ocpt_trim_slew.sv]
/*
  Walks the applied trim one step toward the written trim every STEP_CYC
  cycles. Assumes the target is a two's complement offset.
*/
`timescale 1ns/100ps
`default_nettype none

module ocpt_trim_slew #(
  parameter int W = 6,
  parameter int STEP_CYC = 3906
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] target,
  output logic [W-1:0] applied
);

  localparam int CW = $clog2(STEP_CYC + 1);
  logic [CW-1:0] cnt;
  wire tick = cnt == CW'(STEP_CYC - 1);
  wire moving = applied != target;
  wire up = $signed(target) > $signed(applied);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      applied <= '0;
    end else begin
      cnt <= (!moving || tick) ? '0 : cnt + 1'b1;
      if (moving && tick) begin
        applied <= up ? applied + 1'b1 : applied - 1'b1;
      end
    end
  end

  property p_one_step;
    @(posedge clk) disable iff (rst)
    $changed(applied) |-> (applied - $past(applied) == W'(1)) || ($past(applied) - applied == W'(1));
  endproperty
  a_one_step: assert property (p_one_step) else $error("Trim jumped by more than one step");

endmodule // ocpt_trim_slew

`default_nettype wire

// [tb/ocpt_clk_src.sv]
/*
  Partner model: external clock source on the clock input pin.
  Assumes it is stepped by the system clock; HALF sets the half period.
*/
`timescale 1ns/100ps
`default_nettype none

module ocpt_clk_src #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic run,
  output logic src
);
  int cnt;

  // Stopped source stands still low, like a gated oscillator
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      src <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      src <= !src;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // ocpt_clk_src

`default_nettype wire

// [tb/ocpt_bench.sv]
/*
  Bench of the oscillator control block: register bus, pins, levels.
  Assumes a short trim settle time and one external clock partner.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ocpt_consts.svh"

module ocpt_bench import ocpt_pkg::*;;
  localparam int SETTLE = 128;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic src_run = 1'b0;
  logic out_float = 1'b0;
  logic src_clk, pin_in, pin_out, HREADYOUT, HRESP;
  logic [31:0] HRDATA;
  logic CLOCK_IN_PIN_O, CLOCK_IN_PIN_OE, CLOCK_OUT_PIN_O, CLOCK_OUT_PIN_OE;
  logic PLL_ON, START_DELAY_EN, FAST_RC_ON, FAST_RC_DIRECT, SLOW_RC_ON, PINS_AS_PORT;
  logic [2:0] PLL_MULT, POSTSCALE_SEL;
  logic [5:0] FAST_RC_TRIM;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #2 SYS_CLK = !SYS_CLK;
  // Undriven pin toggles so a stale level never passes for a drive
  always @(posedge SYS_CLK) out_float <= !out_float;
  assign pin_in = CLOCK_IN_PIN_OE ? CLOCK_IN_PIN_O : src_clk;
  assign pin_out = CLOCK_OUT_PIN_OE ? CLOCK_OUT_PIN_O : out_float;

  ocpt_clk_src #(.HALF(4)) src_u (.clk(SYS_CLK), .run(src_run), .src(src_clk));

  ocpt_top #(.SETTLE_CYC(SETTLE)) dut_u (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CLOCK_IN_PIN_I(pin_in), .CLOCK_IN_PIN_O(CLOCK_IN_PIN_O),
    .CLOCK_IN_PIN_OE(CLOCK_IN_PIN_OE), .CLOCK_OUT_PIN_I(pin_out), .CLOCK_OUT_PIN_O(CLOCK_OUT_PIN_O),
    .CLOCK_OUT_PIN_OE(CLOCK_OUT_PIN_OE), .PLL_ON(PLL_ON), .PLL_MULT(PLL_MULT),
    .START_DELAY_EN(START_DELAY_EN), .FAST_RC_ON(FAST_RC_ON), .FAST_RC_DIRECT(FAST_RC_DIRECT),
    .POSTSCALE_SEL(POSTSCALE_SEL), .FAST_RC_TRIM(FAST_RC_TRIM), .SLOW_RC_ON(SLOW_RC_ON),
    .PINS_AS_PORT(PINS_AS_PORT)
  );

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Run is a few hundred cycles; the ceiling leaves ample slack
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    hsel <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge SYS_CLK);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    htrans <= 2'h0;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    d = HRDATA;
    hsel <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd(`OCPT_A_CTRL, d);
    chk("freq reset", 32'h40, d);
    rd(`OCPT_A_STAT, d);
    chk("stat reset", 32'h2, d);
    chk("no delay", 0, START_DELAY_EN);
  endtask

  task automatic wait_rise(output int n);
    logic p;
    n = 0;
    p = 1'b1;
    while (n < 100 && !(p === 1'b0 && CLOCK_OUT_PIN_O === 1'b1)) begin
      p = CLOCK_OUT_PIN_O;
      @(posedge SYS_CLK);
      #1;
      n++;
    end
  endtask

  task automatic t_divider();
    int n;
    src_run <= 1'b1;
    wait_rise(n);
    wait_rise(n);
    chk("out period", 32, n);
    chk("out oe", 1, CLOCK_OUT_PIN_OE);
  endtask

  task automatic t_crystal();
    int hi;
    hi = 0;
    wr(`OCPT_A_CFG, CFG_CRYSTAL_DRIVE_MODE);
    repeat (100) begin
      @(posedge SYS_CLK);
      #1;
      if (CLOCK_OUT_PIN_O !== 1'b0 || CLOCK_OUT_PIN_OE !== 1'b0) hi++;
    end
    chk("no div out", 0, hi);
    src_run <= 1'b0;
  endtask

  task automatic t_pll();
    ocpt_cfg_e cf [4] = '{CFG_EXT_CLK_INPUT_MODE, CFG_EXT_CLK_TIMES4_MODE,
                          CFG_CRYSTAL_DRIVE_MODE, CFG_CRYSTAL_TIMES4_MODE};
    logic [31:0] d;
    logic on;
    foreach (cf[i]) begin
      on = !cf[i][0];
      wr(`OCPT_A_CFG, cf[i]);
      wr(`OCPT_A_TRIM, 32'h40);
      rd(`OCPT_A_TRIM, d);
      chk("mult bit", on ? 32'h40 : 32'h0, d);
      chk("pll on", on, PLL_ON);
      chk("pll mult", on ? `OCPT_PLL_MULT : `OCPT_NO_MULT, PLL_MULT);
      chk("start delay", cf[i][2:1] == 2'b10, START_DELAY_EN);
      wr(`OCPT_A_TRIM, 32'h0);
      chk("pll off", 0, PLL_ON);
    end
    wr(`OCPT_A_CFG, CFG_EXT_CLK_INPUT_MODE);
  endtask

  task automatic t_freq();
    for (int c = 0; c < 8; c++) begin
      wr(`OCPT_A_CTRL, c << 4);
      chk("postscale", c, POSTSCALE_SEL);
      chk("fast rc on", c != 0, FAST_RC_ON);
      chk("fast direct", c == 7, FAST_RC_DIRECT);
      chk("slow rc on", c == 0, SLOW_RC_ON);
    end
    wr(`OCPT_A_CTRL, 32'h0);
    wr(`OCPT_A_TRIM, 32'h80);
    chk("lfs fast", 1, FAST_RC_ON);
    chk("lfs slow", 0, SLOW_RC_ON);
    wr(`OCPT_A_TRIM, 32'h0);
    wr(`OCPT_A_CTRL, 32'h40);
    for (int i = 0; i < 4; i++) begin
      wr(`OCPT_A_AUX, 1 << i);
      chk("aux slow", 1, SLOW_RC_ON);
    end
    wr(`OCPT_A_AUX, 32'h0);
    chk("aux off", 0, SLOW_RC_ON);
  endtask

  task automatic t_pins();
    logic [31:0] d;
    wr(`OCPT_A_CFG, 32'h3);
    chk("port mode", 1, PINS_AS_PORT);
    wr(`OCPT_A_PORT, 32'hF);
    rd(`OCPT_A_PORT, d);
    chk("port both", 32'h3F, d);
    wr(`OCPT_A_PORT, 32'hE);
    rd(`OCPT_A_PORT, d);
    chk("port data", 32'h2E, d);
    wr(`OCPT_A_PORT, 32'h0);
    chk("in oe", 0, CLOCK_IN_PIN_OE);
    chk("out oe", 0, CLOCK_OUT_PIN_OE);
    wr(`OCPT_A_CFG, 32'h7);
  endtask

  task automatic wait_trim(input logic [5:0] t);
    int n;
    n = 0;
    while (FAST_RC_TRIM !== t && n < SETTLE) begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    chk("trim", t, FAST_RC_TRIM);
  endtask

  task automatic t_trim();
    logic [31:0] d;
    wr(`OCPT_A_CTRL, 32'h0);
    wr(`OCPT_A_TRIM, 32'h3);
    wait_trim(6'h03);
    wr(`OCPT_A_TRIM, 32'h2);
    wait_trim(6'h02);
    wr(`OCPT_A_TRIM, 32'h3E);
    wait_trim(6'h3E);
    rd(`OCPT_A_TRIM, d);
    chk("trim rd", 32'h3E, d);
    wr(`OCPT_A_TRIM, 32'h1F);
    wait_trim(6'h1F);
    // Widest swing, 63 steps, must still fit the settle time
    wr(`OCPT_A_TRIM, 32'h20);
    wait_trim(6'h20);
    chk("slow rc", 1, SLOW_RC_ON);
    wr(`OCPT_A_CTRL, 32'h40);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    wr(32'h20, 32'hFF);
    rd(32'h20, d);
    chk("unmapped", 0, d);
    rd(32'h100, d);
    chk("high addr", 0, d);
    chk("resp", 0, HRESP);
    chk("ready", 1, HREADYOUT);
    wr(32'h104, 32'h3F);
    rd(`OCPT_A_TRIM, d);
    chk("high addr wr", 32'h20, d);
  endtask

  task automatic t_rerst();
    logic [31:0] d;
    wr(`OCPT_A_CTRL, 32'h70);
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    rd(`OCPT_A_CTRL, d);
    chk("freq rerst", 32'h40, d);
    chk("trim rerst", 0, FAST_RC_TRIM);
  endtask

  initial begin
    repeat (12) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_divider();
    t_crystal();
    t_pll();
    t_freq();
    t_pins();
    t_trim();
    t_unmapped();
    t_rerst();
    end_of_test();
  end
endmodule // ocpt_bench

`default_nettype wire
